// >>> spc_defines.svh
// Constants for the serial port configuration register bank
//
// Contract
// - Pin-mode bit steers reads to output pin
// - Bit-order bit selects LSB first, address increment
// - Bit-order setting ignored while in I2C mode
// - Soft reset restores all registers to defaults
// - SPI: soft reset clears on next serial clock
// - I2C: soft reset clears on next I2C clock
// - Readback select chooses buffer or active bank
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH

// ==========================================================
// Register offsets
`define SPC_CFG_OFFSET 12'h000
`define SPC_RBSEL_OFFSET 12'h004

// ==========================================================
// Field positions
`define SPC_CFG_PIN_MODE_BIT 7
`define SPC_CFG_BIT_ORDER_BIT 6
`define SPC_CFG_SOFT_RESET_BIT 5
`define SPC_RBSEL_ACTIVE_BIT 0

// ==========================================================
// Reset values
`define SPC_PIN_MODE_RESET 1'b0
`define SPC_BIT_ORDER_RESET 1'b0
`define SPC_SOFT_RESET_RESET 1'b0
`define SPC_RBSEL_RESET 1'b0
`define SPC_READ_ZERO 8'h00

`endif

// >>> spc_pkg.sv
// Types shared by the serial port configuration register bank
package spc_pkg;

  typedef logic [11:0] spc_addr_t;
  typedef logic [7:0] spc_byte_t;

  // Soft reset self-clear sequence
  typedef enum logic [1:0] {
    SPC_SR_IDLE = 2'b00,
    SPC_SR_WAIT_END = 2'b01,
    SPC_SR_WAIT_CLK = 2'b10
  } spc_sr_state_t;

endpackage

// >>> spc_clk_sync.sv
// Synchroniser and rising-edge finder for the serial clock pin
`timescale 1ns/10ps
module spc_clk_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Serial clock pin
  input wire logic serial_clk,
  // Synchronised view
  output logic serial_clk_rise
);
  logic meta_reg;
  logic sync_reg;
  logic last_reg;
  logic meta_next;
  logic sync_next;
  logic last_next;
  logic rise_next;

  // First stage is read only by the second
  always_comb begin
    meta_next = serial_clk;
    sync_next = meta_reg;
    last_next = sync_reg;
    rise_next = sync_reg & ~last_reg;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      last_reg <= 1'b0;
      serial_clk_rise <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      last_reg <= last_next;
      serial_clk_rise <= rise_next;
    end
  end
endmodule

// >>> spc_config_regs.sv
// Serial port configuration and readback bank select registers
`timescale 1ns/10ps
`include "spc_defines.svh"
module spc_config_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Port mode and serial clock pin
  input wire logic i2c_mode,
  input wire logic serial_clk,
  // Decoded register write from the serial engine
  input wire logic wr_en,
  input wire spc_pkg::spc_addr_t wr_addr,
  input wire spc_pkg::spc_byte_t wr_data,
  input wire logic wr_xfer_done,
  // Register read from the serial engine
  input wire spc_pkg::spc_addr_t rd_addr,
  output spc_pkg::spc_byte_t rd_data,
  // Read bit to be driven onto the pins
  input wire logic rd_bit,
  input wire logic rd_bit_drive,
  // Data pin (two-way) and output pin
  output logic sdio_out,
  output logic sdio_oe,
  output logic serial_output_pin_out,
  output logic serial_output_pin_oe,
  // Configuration seen by the rest of the device
  output logic unidirectional_pin_select,
  output logic lsb_first_addr_incr,
  output logic soft_reset,
  output logic readback_active_sel
);
  import spc_pkg::*;

  // ==========================================================
  // Decoding
  function automatic logic hit(input spc_addr_t a, input spc_addr_t off);
    hit = (a == off);
  endfunction

  // ==========================================================
  // Serial clock edges
  logic sclk_rise;

  spc_clk_sync u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .serial_clk(serial_clk),
    .serial_clk_rise(sclk_rise)
  );

  // ==========================================================
  // Register state
  logic pin_mode_reg;
  logic pin_mode_next;
  logic bit_order_reg;
  logic bit_order_next;
  logic rbsel_reg;
  logic rbsel_next;
  logic sr_bit_reg;
  logic sr_bit_next;
  spc_sr_state_t sr_state_reg;
  spc_sr_state_t sr_state_next;
  logic cfg_wr;
  logic rb_wr;

  always_comb begin
    cfg_wr = wr_en & hit(wr_addr, `SPC_CFG_OFFSET);
    rb_wr = wr_en & hit(wr_addr, `SPC_RBSEL_OFFSET);
    pin_mode_next = pin_mode_reg;
    bit_order_next = bit_order_reg;
    rbsel_next = rbsel_reg;
    sr_bit_next = sr_bit_reg;
    sr_state_next = sr_state_reg;
    // Bits 4 and 3:0 are not stored; mirror copy is rebuilt on read
    if (cfg_wr) begin
      if (!i2c_mode) begin
        pin_mode_next = wr_data[`SPC_CFG_PIN_MODE_BIT];
        bit_order_next = wr_data[`SPC_CFG_BIT_ORDER_BIT];
      end
      // Upper two bits unused in I2C mode, so the write drops them
    end
    // Only the select is kept here; the bank mux sits downstream
    if (rb_wr) begin
      rbsel_next = wr_data[`SPC_RBSEL_ACTIVE_BIT];
    end
    // Self-clear is timed by the host's clock, not ref_clk: a host that
    // parks its clock after the write leaves the bit set until it resumes
    case (sr_state_reg)
      SPC_SR_IDLE: begin
        if (cfg_wr && wr_data[`SPC_CFG_SOFT_RESET_BIT]) begin
          sr_bit_next = 1'b1;
          sr_state_next = SPC_SR_WAIT_END;
        end
      end
      SPC_SR_WAIT_END: begin
        // A clock edge within the write itself must not clear the bit
        if (wr_xfer_done) begin
          sr_state_next = SPC_SR_WAIT_CLK;
        end
      end
      SPC_SR_WAIT_CLK: begin
        // Same edge serves SCLK in SPI and SCL in I2C
        // A pin edge that rose up to three ref_clk cycles before the
        // transfer ended can still count as the first serial cycle
        if (sclk_rise) begin
          sr_bit_next = 1'b0;
          sr_state_next = SPC_SR_IDLE;
        end
      end
      default: begin
        // Unreachable code: drop the bit rather than hang with it set
        sr_bit_next = 1'b0;
        sr_state_next = SPC_SR_IDLE;
      end
    endcase
    // While soft reset stands every field holds its default
    if (sr_bit_next) begin
      pin_mode_next = `SPC_PIN_MODE_RESET;
      bit_order_next = `SPC_BIT_ORDER_RESET;
      rbsel_next = `SPC_RBSEL_RESET;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pin_mode_reg <= `SPC_PIN_MODE_RESET;
      bit_order_reg <= `SPC_BIT_ORDER_RESET;
      rbsel_reg <= `SPC_RBSEL_RESET;
      sr_bit_reg <= `SPC_SOFT_RESET_RESET;
      sr_state_reg <= SPC_SR_IDLE;
    end else begin
      pin_mode_reg <= pin_mode_next;
      bit_order_reg <= bit_order_next;
      rbsel_reg <= rbsel_next;
      sr_bit_reg <= sr_bit_next;
      sr_state_reg <= sr_state_next;
    end
  end

  // ==========================================================
  // Readback and outputs
  spc_byte_t rd_data_next;
  logic hi_pin;
  logic hi_order;
  logic uni_next;
  logic order_next;
  logic sdio_out_next;
  logic sdio_oe_next;
  logic so_out_next;
  logic so_oe_next;
  logic [3:0] cfg_hi_nib;
  logic [3:0] cfg_lo_nib;

  // ==========================================================
  // Configuration read image
  // Upper two bits read zero in I2C mode; bit 4 is never stored
  assign hi_pin = i2c_mode ? 1'b0 : pin_mode_reg;
  assign hi_order = i2c_mode ? 1'b0 : bit_order_reg;
  assign cfg_hi_nib = {hi_pin, hi_order, sr_bit_reg, 1'b0};

  // Lower nibble holds no flops: it is rebuilt from the upper one on
  // every read, so a host in either bit order sees one consistent byte
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_mirror
      assign cfg_lo_nib[gi] = cfg_hi_nib[3 - gi];
    end
  endgenerate

  always_comb begin
    rd_data_next = `SPC_READ_ZERO;
    if (hit(rd_addr, `SPC_CFG_OFFSET)) begin
      // Low nibble reads as reversed high nibble, bit 4 reads zero
      rd_data_next = {cfg_hi_nib, cfg_lo_nib};
    end else if (hit(rd_addr, `SPC_RBSEL_OFFSET)) begin
      rd_data_next = {7'h00, rbsel_reg};
    end
    uni_next = hi_pin;
    order_next = i2c_mode ? 1'b0 : bit_order_reg;
    // Pin steering for read data; output pin floats in two-wire mode
    sdio_out_next = 1'b0;
    sdio_oe_next = 1'b0;
    so_out_next = 1'b0;
    so_oe_next = 1'b0;
    if (rd_bit_drive) begin
      if (uni_next) begin
        so_out_next = rd_bit;
        so_oe_next = 1'b1;
      end else begin
        sdio_out_next = rd_bit;
        sdio_oe_next = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data <= `SPC_READ_ZERO;
      sdio_out <= 1'b0;
      sdio_oe <= 1'b0;
      serial_output_pin_out <= 1'b0;
      serial_output_pin_oe <= 1'b0;
      unidirectional_pin_select <= `SPC_PIN_MODE_RESET;
      lsb_first_addr_incr <= `SPC_BIT_ORDER_RESET;
      soft_reset <= `SPC_SOFT_RESET_RESET;
      readback_active_sel <= `SPC_RBSEL_RESET;
    end else begin
      rd_data <= rd_data_next;
      sdio_out <= sdio_out_next;
      sdio_oe <= sdio_oe_next;
      serial_output_pin_out <= so_out_next;
      serial_output_pin_oe <= so_oe_next;
      unidirectional_pin_select <= uni_next;
      lsb_first_addr_incr <= order_next;
      // Output lags the internal bit by one edge
      soft_reset <= sr_bit_reg;
      readback_active_sel <= rbsel_reg;
    end
  end
endmodule

// >>> spc_host.sv
// Host-side serial clock model
`timescale 1ns/10ps
module spc_host (
  // Frame control
  input wire logic run,
  // Serial clock pin
  output logic serial_clk
);
  // Parked low between frames; odd offset keeps it off the core clock phase
  initial begin
    serial_clk = 1'b0;
    #1.3;
    forever #80 serial_clk = run ? ~serial_clk : 1'b0;
  end
endmodule

// >>> spc_monitor.sv
// Checker for the configuration register bank
`timescale 1ns/10ps
module spc_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Inputs
  input wire logic i2c_mode,
  input wire logic serial_clk,
  input wire logic wr_en,
  input wire spc_pkg::spc_addr_t wr_addr,
  input wire spc_pkg::spc_byte_t wr_data,
  input wire logic wr_xfer_done,
  input wire spc_pkg::spc_addr_t rd_addr,
  input wire logic rd_bit_drive,
  // Outputs
  input wire spc_pkg::spc_byte_t rd_data,
  input wire logic sdio_oe,
  input wire logic serial_output_pin_oe,
  input wire logic unidirectional_pin_select,
  input wire logic lsb_first_addr_incr,
  input wire logic soft_reset,
  input wire logic readback_active_sel
);
  import spc_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire cw = wr_en && wr_addr == 12'h000;
  // Pin edge is seen late through the synchroniser
  sequence s_arm; soft_reset && wr_xfer_done ##[1:40] $rose(serial_clk); endsequence
  property p_cfg; cw && !i2c_mode && !wr_data[5] && !soft_reset |-> ##2
    unidirectional_pin_select == $past(wr_data[7], 2) && lsb_first_addr_incr == $past(wr_data[6], 2); endproperty
  a_cfg: assert property (p_cfg) else $error("cfg load");
  property p_i2c; i2c_mode && $past(i2c_mode) |-> !lsb_first_addr_incr; endproperty
  a_i2c: assert property (p_i2c) else $error("i2c order");
  property p_uni; rd_bit_drive && unidirectional_pin_select |=> serial_output_pin_oe && !sdio_oe; endproperty
  a_uni: assert property (p_uni) else $error("uni pin");
  property p_bi; rd_bit_drive && !unidirectional_pin_select |=> sdio_oe && !serial_output_pin_oe; endproperty
  a_bi: assert property (p_bi) else $error("bi pin");
  property p_srs; cw && wr_data[5] |-> ##2 soft_reset; endproperty
  a_srs: assert property (p_srs) else $error("sr set");
  property p_srd; soft_reset |-> !unidirectional_pin_select && !readback_active_sel; endproperty
  a_srd: assert property (p_srd) else $error("sr dflt");
  property p_src; s_arm |-> ##[1:8] !soft_reset; endproperty
  a_src: assert property (p_src) else $error("sr clr");
  property p_rd; $past(rd_addr) == 12'h000 |->
    rd_data[4:3] == 2'h0 && rd_data[2:0] == {rd_data[5], rd_data[6], rd_data[7]}; endproperty
  a_rd: assert property (p_rd) else $error("cfg rd");
endmodule
bind spc_config_regs spc_chk i_spc_chk (.*);

// >>> tb_top.sv
// Self-checking bench for the configuration register bank
`timescale 1ns/10ps
module tb_top;
  import spc_pkg::*;
  logic ref_clk, rst, i2c_mode, serial_clk, wr_en, wr_xfer_done, rd_bit, rd_bit_drive, run;
  logic sdio_out, sdio_oe, serial_output_pin_out, serial_output_pin_oe;
  logic unidirectional_pin_select, lsb_first_addr_incr, soft_reset, readback_active_sel;
  spc_addr_t wr_addr, rd_addr;
  spc_byte_t wr_data, rd_data, st, pv;
  int n_errors = 0;
  int num_checks = 0;
  assign st = {4'h0, unidirectional_pin_select, lsb_first_addr_incr, soft_reset, readback_active_sel};
  assign pv = {4'h0, sdio_oe, sdio_out, serial_output_pin_oe, serial_output_pin_out};
  spc_config_regs i_spc_config_regs (.*);
  spc_host i_spc_host (.*);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input spc_byte_t got, input spc_byte_t exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input spc_addr_t a, input spc_byte_t d);
    @(negedge ref_clk) {wr_en, wr_addr, wr_data} = {1'b1, a, d};
    @(negedge ref_clk) wr_en = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask
  task automatic rd(input spc_addr_t a, input spc_byte_t e);
    @(negedge ref_clk) rd_addr = a;
    @(negedge ref_clk) chk(rd_data, e);
  endtask
  task automatic pin(input spc_byte_t e);
    @(negedge ref_clk) rd_bit_drive = 1'b1;
    @(negedge ref_clk) chk(pv, e);
    rd_bit_drive = 1'b0;
  endtask
  task automatic srst(input logic m);
    int k;
    i2c_mode = m;
    wr(12'h004, 8'h01);
    wr(12'h000, 8'hA5);
    chk(st, 8'h02);
    run = 1'b1;
    // Clock edges before the transfer ends must not clear it
    repeat (60) @(negedge ref_clk);
    chk(st, 8'h02);
    wr_xfer_done = 1'b1;
    @(negedge ref_clk) wr_xfer_done = 1'b0;
    for (k = 0; k < 40 && soft_reset; k++) @(negedge ref_clk);
    if (soft_reset) begin
      n_errors++;
      report_and_stop();
    end
    run = 1'b0;
    rd(12'h004, 8'h00);
    rd(12'h000, 8'h00);
  endtask
  initial begin
    {rst, i2c_mode, wr_en, wr_xfer_done, rd_bit, rd_bit_drive, run} = 7'h44;
    {wr_addr, rd_addr, wr_data} = 32'h0;
    repeat (10) @(negedge ref_clk);
    rst = 1'b0;
    rd(12'h000, 8'h00);
    rd(12'h004, 8'h00);
    pin(8'h0C);
    wr(12'h000, 8'hC3);
    chk(st, 8'h0C);
    pin(8'h03);
    wr(12'h004, 8'hFF);
    wr(12'h008, 8'hFF);
    chk(st, 8'h0D);
    rd(12'h000, 8'hC3);
    rd(12'h004, 8'h01);
    i2c_mode = 1'b1;
    wr(12'h000, 8'hC3);
    chk(st, 8'h01);
    rd(12'h000, 8'h00);
    // A write in I2C mode must leave the stored upper bits alone
    wr(12'h000, 8'h00);
    i2c_mode = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(st, 8'h0D);
    srst(1'b0);
    srst(1'b1);
    report_and_stop();
  end
endmodule
